// File: rtl/tin_pkg.sv
// package: offsets, field positions, reset values and function codes of the timer input block
package tin_pkg;
   // ****************************************************
   // register byte offsets
   // ****************************************************
   localparam logic [4:0] OFS_INPUT_CTRL  = 5'h00;
   localparam logic [4:0] OFS_TIMER_MODE  = 5'h04;
   localparam logic [4:0] OFS_TIMER_CTRL  = 5'h08;
   localparam logic [4:0] OFS_STATUS      = 5'h0c;
   localparam logic [4:0] OFS_REG_ZERO    = 5'h10;
   localparam logic [4:0] OFS_REG_ONE     = 5'h14;

   // ****************************************************
   // field positions
   // ****************************************************
   localparam int FLD_FUNC_LSB   = 0;   // input_function_sel [3:0]
   localparam int FLD_A_EDGE_LSB = 4;   // input_a_edge_sel [5:4]
   localparam int FLD_B_EDGE_LSB = 6;   // input_b_edge_sel [7:6]
   localparam int FLD_RM0        = 0;   // reg_zero_capture_sel
   localparam int FLD_RM1        = 1;   // reg_one_capture_sel
   localparam int FLD_DUAL       = 2;   // dual_value_enable
   localparam int FLD_SW_DIR     = 0;   // sw_count_direction, 1 = up
   localparam int FLD_RUN        = 1;   // counter run enable
   localparam int FLD_DIR_STAT   = 16;  // status: effective direction

   // ****************************************************
   // reset values and counts
   // ****************************************************
   localparam logic [7:0]  RST_INPUT_CTRL = 8'h00;
   localparam logic [2:0]  RST_TIMER_MODE = 3'h0;
   localparam logic [1:0]  RST_TIMER_CTRL = 2'h1;
   localparam logic [15:0] RST_COUNT      = 16'h0000;
   localparam logic [1:0]  PRESC_DIV      = 2'h3;   // internal prescaler clock = clk / 3

   // ****************************************************
   // edge selection and input function codes
   // ****************************************************
   localparam logic [1:0] EDGE_NONE = 2'h0;
   localparam logic [1:0] EDGE_RISE = 2'h1;
   localparam logic [1:0] EDGE_FALL = 2'h2;
   localparam logic [1:0] EDGE_BOTH = 2'h3;

   typedef enum logic [3:0] {
      FN_IO_IO, FN_IO_TRIG, FN_GATE_IO, FN_GATE_TRIG, FN_IO_EXTCLK, FN_TRIG_IO,
      FN_GATE_EXTCLK, FN_TRIG_TRIG, FN_CLKUP_CLKDN, FN_UD_EXTCLK, FN_TRIGUP_TRIGDN,
      FN_UD_IO, FN_AUTODISC, FN_TRIG_EXTCLK, FN_EXTCLK_TRIG, FN_TRIG_GATE
   } func_t;
endpackage

// File: rtl/pin_edge_detect.sv
// module: samples one timer input pin and flags its selected edges
`timescale 1ns/1ps
module pin_edge_detect
   import tin_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       ce,
   input  wire logic       pin,
   input  wire logic [1:0] edge_sel,
   output logic            level,
   output logic            rise,
   output logic            fall,
   output logic            sel_event
);
   logic level_q;
   logic prev_q;

   // two stages so every edge is seen exactly once per sampled transition
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         level_q <= 1'b0;
         prev_q  <= 1'b0;
      end else if (ce) begin
         level_q <= pin;
         prev_q  <= level_q;
      end
   end

   assign level = level_q;
   assign rise  = level_q & ~prev_q;
   assign fall  = ~level_q & prev_q;

   // per-input sensitivity: rising, falling or both
   assign sel_event = (edge_sel[0] & rise) | (edge_sel[1] & fall);
endmodule

// File: rtl/timer_input_pin_assignment.sv
// module: input pin assignment of a 16-bit timer, with its counter hooks and Avalon-MM registers
`timescale 1ns/1ps
module timer_input_pin_assignment
   import tin_pkg::*;
#(
   parameter int CNT_W = 16
) (
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             ce,
   input  wire logic             timer_input_a,
   input  wire logic             timer_input_b,
   input  wire logic [4:0]       avm_address,
   input  wire logic             avm_read,
   input  wire logic             avm_write,
   input  wire logic [31:0]      avm_writedata,
   input  wire logic [3:0]       avm_byteenable,
   output logic [31:0]           avm_readdata,
   output logic                  avm_waitrequest,
   output logic [CNT_W-1:0]      count_value,
   output logic                  count_up
);
   // ****************************************************
   // registers
   // ****************************************************
   logic [7:0]       input_control_reg_q;
   logic [2:0]       timer_mode_reg_q;
   logic [1:0]       timer_control_reg_q;
   logic [CNT_W-1:0] reload_capture_reg_zero_q;
   logic [CNT_W-1:0] reload_capture_reg_one_q;
   logic [CNT_W-1:0] count_q;
   logic [CNT_W-1:0] count_d;
   logic             trig_dir_q;
   logic [1:0]       presc_q;
   logic             wait_q;
   logic [31:0]      rdata_q;
   logic             dir_q;

   func_t            fn;
   logic             a_lvl, a_rise, a_fall, a_ev;
   logic             b_lvl, b_rise, b_fall, b_ev_raw, b_ev;
   logic             dual_en, rm0;
   logic             sw_dir, run;
   logic             int_clk, ext_b_clk, ext_a_clk;
   logic             gate_a, gate_b, gate_open;
   logic             trig_a, trig_b, trig_a_any;
   logic             int_tick, ext_tick, step, dir_eff;
   logic             ud_up, ud_dn;
   logic             a_load, a_capt;
   logic             acc, wr_en;

   assign fn      = func_t'(input_control_reg_q[FLD_FUNC_LSB +: 4]);
   assign dual_en = timer_mode_reg_q[FLD_DUAL];
   assign rm0     = timer_mode_reg_q[FLD_RM0];
   assign sw_dir  = timer_control_reg_q[FLD_SW_DIR];
   assign run     = timer_control_reg_q[FLD_RUN];

   // ****************************************************
   // pin sampling and edge detection
   // ****************************************************
   pin_edge_detect u_edge_a (
      .clk       (clk),
      .reset_n   (reset_n),
      .ce        (ce),
      .pin       (timer_input_a),
      .edge_sel  (input_control_reg_q[FLD_A_EDGE_LSB +: 2]),
      .level     (a_lvl),
      .rise      (a_rise),
      .fall      (a_fall),
      .sel_event (a_ev)
   );

   pin_edge_detect u_edge_b (
      .clk       (clk),
      .reset_n   (reset_n),
      .ce        (ce),
      .pin       (timer_input_b),
      .edge_sel  (input_control_reg_q[FLD_B_EDGE_LSB +: 2]),
      .level     (b_lvl),
      .rise      (b_rise),
      .fall      (b_fall),
      .sel_event (b_ev_raw)
   );

   // input B is cut off entirely while dual-value mode is on
   assign b_ev = b_ev_raw & ~dual_en;

   // ****************************************************
   // role decode
   // ****************************************************
   assign ext_b_clk = (fn == FN_IO_EXTCLK) || (fn == FN_GATE_EXTCLK) ||
                      (fn == FN_UD_EXTCLK) || (fn == FN_TRIG_EXTCLK);
   assign ext_a_clk = (fn == FN_EXTCLK_TRIG);
   assign int_clk   = !ext_b_clk && !ext_a_clk && (fn != FN_CLKUP_CLKDN) && (fn != FN_AUTODISC);
   assign gate_a    = (fn == FN_GATE_IO) || (fn == FN_GATE_TRIG) || (fn == FN_GATE_EXTCLK);
   assign gate_b    = (fn == FN_TRIG_GATE) && !dual_en;
   // gates are active low: open while the gate pin is low
   assign gate_open = !(gate_a && a_lvl) && !(gate_b && b_lvl);
   assign trig_a    = (fn == FN_TRIG_IO) || (fn == FN_TRIG_TRIG) ||
                      (fn == FN_TRIG_EXTCLK) || (fn == FN_TRIG_GATE);
   assign trig_b    = ((fn == FN_IO_TRIG) || (fn == FN_GATE_TRIG) ||
                       (fn == FN_TRIG_TRIG) || (fn == FN_EXTCLK_TRIG)) && b_ev;
   assign trig_a_any = trig_a && a_ev;
   assign a_load    = trig_a_any && !rm0;
   assign a_capt    = trig_a_any && rm0;

   // ****************************************************
   // direction
   // ****************************************************
   // pin level, latched pin direction or the counting B edge overrides the software bit
   always_comb begin
      unique case (fn)
         FN_UD_EXTCLK, FN_UD_IO: dir_eff = a_lvl;
         FN_TRIGUP_TRIGDN:       dir_eff = trig_dir_q;
         FN_CLKUP_CLKDN:         dir_eff = !b_ev;
         FN_AUTODISC:            dir_eff = !ud_dn;
         default:                dir_eff = sw_dir;
      endcase
   end

   // down latch checked first so B has priority on a tie
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         trig_dir_q <= 1'b1;
      end else if (ce && fn == FN_TRIGUP_TRIGDN) begin
         if (b_ev) begin
            trig_dir_q <= 1'b0;
         end else if (a_ev) begin
            trig_dir_q <= 1'b1;
         end
      end
   end

   // ****************************************************
   // prescaler and count steps
   // ****************************************************
   // divide-by-three tick; held while gated so a reopening gate resumes mid-period
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         presc_q <= 2'h0;
      end else if (ce && run && int_clk && gate_open) begin
         presc_q <= (presc_q == PRESC_DIV - 2'h1) ? 2'h0 : presc_q + 2'h1;
      end
   end
   assign int_tick = run && int_clk && gate_open && (presc_q == PRESC_DIV - 2'h1);

   // autodiscrimination: B rising with A low counts up, B falling with A high counts down
   assign ud_up = (fn == FN_AUTODISC) && !dual_en && b_rise && !a_lvl;
   assign ud_dn = (fn == FN_AUTODISC) && !dual_en && b_fall && a_lvl;

   // external edges count once each; gated B clock passes only while A is low
   assign ext_tick = run && ((ext_b_clk && b_ev && gate_open) ||
                             (ext_a_clk && a_ev) ||
                             ((fn == FN_CLKUP_CLKDN) && (a_ev || b_ev)) ||
                             ud_up || ud_dn);
   assign step = int_tick || ext_tick;

   // a reload wins over a step in the same cycle
   always_comb begin
      count_d = count_q;
      if (a_load) begin
         count_d = reload_capture_reg_zero_q;
      end else if (step) begin
         count_d = dir_eff ? count_q + CNT_W'(1) : count_q - CNT_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count_q <= RST_COUNT;
         dir_q   <= 1'b1;
      end else if (ce) begin
         count_q <= count_d;
         dir_q   <= dir_eff;
      end
   end

   // ****************************************************
   // Avalon-MM slave: one wait cycle per access
   // ****************************************************
   assign acc   = (avm_read || avm_write) && wait_q;
   assign wr_en = avm_write && acc && avm_byteenable[0];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0000_0000;
      end else if (ce) begin
         wait_q <= !acc;
         if (acc && avm_read) begin
            unique case (avm_address)
               OFS_INPUT_CTRL: rdata_q <= {24'h000000, input_control_reg_q};
               OFS_TIMER_MODE: rdata_q <= {29'h00000000, timer_mode_reg_q};
               OFS_TIMER_CTRL: rdata_q <= {30'h00000000, timer_control_reg_q};
               OFS_STATUS:     rdata_q <= {15'h0000, dir_q, count_q};
               OFS_REG_ZERO:   rdata_q <= {16'h0000, reload_capture_reg_zero_q};
               OFS_REG_ONE:    rdata_q <= {16'h0000, reload_capture_reg_one_q};
               default:        rdata_q <= 32'h0000_0000; // unmapped reads zero
            endcase
         end
      end
   end

   // control registers; low byte lane only
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         input_control_reg_q <= RST_INPUT_CTRL;
         timer_mode_reg_q    <= RST_TIMER_MODE;
         timer_control_reg_q <= RST_TIMER_CTRL;
      end else if (ce && wr_en) begin
         if (avm_address == OFS_INPUT_CTRL) begin
            input_control_reg_q <= avm_writedata[7:0];
         end
         if (avm_address == OFS_TIMER_MODE) begin
            timer_mode_reg_q <= avm_writedata[2:0];
         end
         if (avm_address == OFS_TIMER_CTRL) begin
            timer_control_reg_q <= avm_writedata[1:0];
         end
      end
   end

   // capture events win over a software write in the same cycle
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         reload_capture_reg_zero_q <= RST_COUNT;
         reload_capture_reg_one_q  <= RST_COUNT;
      end else if (ce) begin
         if (a_capt) begin
            reload_capture_reg_zero_q <= count_q;
         end else if (avm_write && acc && avm_address == OFS_REG_ZERO) begin
            if (avm_byteenable[0]) reload_capture_reg_zero_q[7:0]  <= avm_writedata[7:0];
            if (avm_byteenable[1]) reload_capture_reg_zero_q[15:8] <= avm_writedata[15:8];
         end
         if (trig_b) begin
            reload_capture_reg_one_q <= count_q;
         end else if (avm_write && acc && avm_address == OFS_REG_ONE) begin
            if (avm_byteenable[0]) reload_capture_reg_one_q[7:0]  <= avm_writedata[7:0];
            if (avm_byteenable[1]) reload_capture_reg_one_q[15:8] <= avm_writedata[15:8];
         end
      end
   end

   assign avm_waitrequest = wait_q;
   assign avm_readdata    = rdata_q;
   assign count_value     = count_q;
   assign count_up        = dir_q;

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge clk iff ce); endclocking
   default disable iff (!reset_n);

   sequence s_req;
      (avm_read || avm_write) && wait_q;
   endsequence
   sequence s_done;
      !wait_q ##1 wait_q;
   endsequence

   AST_PRESC_SPACING: assert property (int_tick |=> !int_tick [*2])
      else $error("prescaler ticks closer than three cycles");
   AST_GATE_A_HOLD: assert property (gate_a && a_lvl && int_clk && !a_load |=> $stable(count_q))
      else $error("counter moved while gate A high");
   AST_TRIG_A_LOAD: assert property (a_load |=> count_q == $past(reload_capture_reg_zero_q))
      else $error("trigger A did not reload counter");
   AST_TRIG_A_CAPT: assert property (a_capt |=> reload_capture_reg_zero_q == $past(count_q))
      else $error("trigger A did not capture count");
   AST_TRIG_B_CAPT: assert property (trig_b |=> reload_capture_reg_one_q == $past(count_q))
      else $error("trigger B did not capture count");
   // only a software write may move register one while input B is cut off
   AST_DUAL_B_OFF: assert property (dual_en && !(avm_write && acc && avm_address == OFS_REG_ONE) |=>
         $stable(reload_capture_reg_one_q))
      else $error("input B captured in dual-value mode");
   AST_DUAL_B_CLK_OFF: assert property (dual_en && (fn == FN_IO_EXTCLK) |=> $stable(count_q))
      else $error("input B clocked the counter in dual-value mode");
   AST_CLKUD_B_WINS: assert property ((fn == FN_CLKUP_CLKDN) && run && b_ev |=>
         count_q == $past(count_q) - CNT_W'(1))
      else $error("clock-down pulse did not decrement");
   AST_UD_LEVEL: assert property (((fn == FN_UD_IO) && int_tick) || ((fn == FN_UD_EXTCLK) && ext_tick)
         |=> count_q == ($past(a_lvl) ? $past(count_q) + CNT_W'(1) : $past(count_q) - CNT_W'(1)))
      else $error("direction pin not obeyed");
   AST_AUTO_NOCOUNT: assert property ((fn == FN_AUTODISC) && b_rise && a_lvl |=> $stable(count_q))
      else $error("autodiscrimination counted on B rise with A high");
   AST_BUS_ANSWER: assert property (s_req |=> s_done)
      else $error("bus access not answered after one wait cycle");
endmodule

// File: verif/pulse_source.sv
// partner model: external pulse and level sources that drive the two timer inputs
`timescale 1ns/1ps
module pulse_source #(
   parameter int PW  = 4,   // beyond one prescaler period, so both edges of a pulse stay far enough apart
   parameter int GAP = 3    // quiet time after each pulse
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic pulse_a,
   input  wire logic pulse_b,
   input  wire logic lvl_a,
   input  wire logic lvl_b,
   output logic      pin_a,
   output logic      pin_b,
   output logic      busy
);
   logic [3:0] cnt_q;
   logic       act_a_q;
   logic       act_b_q;

   // a pulse inverts the resting level for PW cycles, then a gap; requests during a pulse are dropped
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_q   <= 4'h0;
         act_a_q <= 1'b0;
         act_b_q <= 1'b0;
      end else if (cnt_q == 4'h0) begin
         if (pulse_a || pulse_b) begin
            cnt_q   <= 4'(PW + GAP);
            act_a_q <= pulse_a;
            act_b_q <= pulse_b;
         end
      end else begin
         cnt_q <= cnt_q - 4'h1;
         if (cnt_q == 4'(GAP + 1)) begin
            act_a_q <= 1'b0;
            act_b_q <= 1'b0;
         end
      end
   end

   // levels come from the bench and only move while no pulse runs
   assign pin_a = lvl_a ^ act_a_q;
   assign pin_b = lvl_b ^ act_b_q;
   assign busy  = (cnt_q != 4'h0) | pulse_a | pulse_b;
endmodule

// File: verif/timer_input_pin_assignment_tb.sv
// testbench: register access and input pin roles of the timer input block
`timescale 1ns/1ps
module timer_input_pin_assignment_tb;
   import tin_pkg::*;
   logic        clk, reset_n, ce, pin_a, pin_b, busy, pulse_a, pulse_b, lvl_a, lvl_b;
   logic [4:0]  avm_address;
   logic        avm_read, avm_write, avm_waitrequest;
   logic [31:0] avm_writedata, avm_readdata, seed;
   logic [3:0]  avm_byteenable;
   logic [63:0] note, exp_q[$];
   logic [15:0] cnt, z;
   int          miscompares, samples_checked, cyc, k;

   timer_input_pin_assignment u_timer_input_pin_assignment (.clk(clk), .reset_n(reset_n), .ce(ce),
      .timer_input_a(pin_a), .timer_input_b(pin_b), .avm_address(avm_address), .avm_read(avm_read),
      .avm_write(avm_write), .avm_writedata(avm_writedata), .avm_byteenable(avm_byteenable),
      .avm_readdata(avm_readdata), .avm_waitrequest(avm_waitrequest), .count_value(), .count_up());
   pulse_source u_pulse_source (.clk(clk), .reset_n(reset_n), .pulse_a(pulse_a), .pulse_b(pulse_b),
      .lvl_a(lvl_a), .lvl_b(lvl_b), .pin_a(pin_a), .pin_b(pin_b), .busy(busy));

   // ****************************************************
   // shared tasks
   // ****************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [31:0] st(input logic d, input logic [15:0] c);
      return {15'h0, d, c};
   endfunction
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // request held until waitrequest is sampled low, released at that edge
   task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      avm_address   <= a;
      avm_writedata <= d;
      avm_read      <= rd;
      avm_write     <= !rd;
      do @(posedge clk); while (avm_waitrequest !== 1'b0);
      avm_read  <= 1'b0;
      avm_write <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffffffff);
      exp_q.push_back({m, e & m});
      bus(1'b1, a, 32'h0);
   endtask
   task automatic input_control_reg(input func_t f, input logic [1:0] ea, input logic [1:0] eb);
      wr(OFS_INPUT_CTRL, {24'h0, eb, ea, 4'(f)});
   endtask
   task automatic pulse(input logic a, input logic b);
      @(posedge clk);
      pulse_a <= a;
      pulse_b <= b;
      @(posedge clk);
      pulse_a <= 1'b0;
      pulse_b <= 1'b0;
      do @(posedge clk); while (busy === 1'b1);
   endtask
   task automatic set_lvl(input logic a, input logic b);
      @(posedge clk);
      lvl_a <= a;
      lvl_b <= b;
   endtask
   task automatic test_done;
      $display("mismatches %0d of %0d checks", miscompares, samples_checked);
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ****************************************************
   // clock, watchdog and read monitor
   // ****************************************************
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // a hang is cut short well beyond the few hundred cycles the run needs
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         test_done();
      end
   end
   // each completed read takes the oldest note
   always @(posedge clk) begin
      if (avm_read === 1'b1 && avm_waitrequest === 1'b0) begin
         note = exp_q.pop_front();
         check("readdata", avm_readdata & note[63:32], note[31:0]);
      end
   end

   // ****************************************************
   // scenarios
   // ****************************************************
   initial begin
      {reset_n, pulse_a, pulse_b, lvl_a, lvl_b, avm_read, avm_write} = '0;
      avm_address = 5'h00;
      avm_writedata = 32'h0;
      avm_byteenable = 4'hf;
      ce = 1'b1;
      seed = 32'd97788;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      rd(OFS_INPUT_CTRL, 32'h0);
      rd(OFS_TIMER_MODE, 32'h0);
      rd(OFS_TIMER_CTRL, 32'h1);
      rd(OFS_STATUS, st(1'b1, 16'h0));
      wr(5'h18, 32'hffffffff);
      rd(5'h18, 32'h0);
      for (k = 0; k < 16; k++) begin
         wr(OFS_INPUT_CTRL, {24'hffffff, 4'(k ^ 5), 4'(k)});
         rd(OFS_INPUT_CTRL, {24'h0, 4'(k ^ 5), 4'(k)});
      end
      avm_byteenable <= 4'he;   // lane 0 off: control write ignored
      wr(OFS_INPUT_CTRL, 32'h0);
      avm_byteenable <= 4'hf;
      rd(OFS_INPUT_CTRL, 32'haf);
      // trigger on A reloads, then B captures, then A captures
      seed = lfsr(seed);
      z = seed[15:0];
      wr(OFS_REG_ZERO, {16'hffff, z});
      rd(OFS_REG_ZERO, {16'h0, z});
      cnt = z;
      input_control_reg(FN_TRIG_IO, EDGE_RISE, EDGE_NONE);
      pulse(1'b1, 1'b0);
      rd(OFS_STATUS, st(1'b1, cnt));
      input_control_reg(FN_IO_TRIG, EDGE_NONE, EDGE_FALL);
      pulse(1'b0, 1'b1);
      rd(OFS_REG_ONE, {16'h0, cnt});
      wr(OFS_TIMER_MODE, 32'h1);
      wr(OFS_REG_ZERO, {16'h0, ~z});
      input_control_reg(FN_TRIG_IO, EDGE_RISE, EDGE_NONE);
      pulse(1'b1, 1'b0);
      rd(OFS_REG_ZERO, {16'h0, cnt});
      wr(OFS_TIMER_MODE, 32'h0);
      // external clock on B, both edges, software direction
      input_control_reg(FN_IO_EXTCLK, EDGE_NONE, EDGE_BOTH);
      wr(OFS_TIMER_CTRL, 32'h3);
      pulse(1'b0, 1'b1);
      pulse(1'b0, 1'b1);
      wr(OFS_TIMER_CTRL, 32'h2);
      pulse(1'b0, 1'b1);
      pulse(1'b1, 1'b0);
      cnt = cnt + 16'h2;
      rd(OFS_STATUS, st(1'b0, cnt));
      wr(OFS_TIMER_MODE, 32'h4);
      pulse(1'b0, 1'b1);
      rd(OFS_STATUS, st(1'b0, cnt));
      // A clocks with no edge selected, so no internal tick moves the count meanwhile
      input_control_reg(FN_EXTCLK_TRIG, EDGE_NONE, EDGE_RISE);
      pulse(1'b0, 1'b1);
      rd(OFS_REG_ONE, {16'h0, z});
      wr(OFS_TIMER_MODE, 32'h0);
      // clock up on A, clock down on B, B wins a tie
      input_control_reg(FN_CLKUP_CLKDN, EDGE_RISE, EDGE_RISE);
      for (k = 0; k < 3; k++)
         pulse(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      pulse(1'b1, 1'b1);
      cnt = cnt + 16'h1;
      rd(OFS_STATUS, {16'h0, cnt}, 32'hffff);
      // A level sets direction over the software bit
      input_control_reg(FN_UD_EXTCLK, EDGE_NONE, EDGE_RISE);
      set_lvl(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      pulse(1'b0, 1'b1);
      cnt = cnt + 16'h2;
      rd(OFS_STATUS, st(1'b1, cnt));
      set_lvl(1'b0, 1'b0);
      pulse(1'b0, 1'b1);
      cnt = cnt - 16'h1;
      rd(OFS_STATUS, st(1'b0, cnt));
      // a frozen block must let a whole pulse pass unseen
      ce <= 1'b0;
      pulse(1'b0, 1'b1);
      ce <= 1'b1;
      rd(OFS_STATUS, st(1'b0, cnt));
      // gated external clock: edges pass only while A is low
      input_control_reg(FN_GATE_EXTCLK, EDGE_NONE, EDGE_RISE);
      set_lvl(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      set_lvl(1'b0, 1'b0);
      pulse(1'b0, 1'b1);
      cnt = cnt - 16'h1;   // software direction is down here
      rd(OFS_STATUS, st(1'b0, cnt));
      // autodiscrimination: two up steps with A low, one down with A high
      input_control_reg(FN_AUTODISC, EDGE_NONE, EDGE_NONE);
      pulse(1'b0, 1'b1);
      pulse(1'b0, 1'b1);
      set_lvl(1'b1, 1'b0);
      pulse(1'b0, 1'b1);
      cnt = cnt + 16'h1;
      rd(OFS_STATUS, {16'h0, cnt}, 32'hffff);
      // external clock on A, B captures into register one
      input_control_reg(FN_EXTCLK_TRIG, EDGE_RISE, EDGE_RISE);
      set_lvl(1'b0, 1'b0);
      pulse(1'b1, 1'b0);
      pulse(1'b1, 1'b0);
      cnt = cnt - 16'h2;
      pulse(1'b0, 1'b1);
      rd(OFS_REG_ONE, {16'h0, cnt});
      // trigger pulses latch direction, B has priority
      wr(OFS_TIMER_CTRL, 32'h0);
      input_control_reg(FN_TRIGUP_TRIGDN, EDGE_RISE, EDGE_RISE);
      pulse(1'b1, 1'b1);
      rd(OFS_STATUS, st(1'b0, cnt));
      pulse(1'b1, 1'b0);
      rd(OFS_STATUS, st(1'b1, cnt));
      // closed gates hold the internally clocked counter
      input_control_reg(FN_TRIG_GATE, EDGE_RISE, EDGE_NONE);
      set_lvl(1'b0, 1'b1);
      seed = lfsr(seed);
      z = seed[15:0];
      wr(OFS_REG_ZERO, {16'h0, z});
      wr(OFS_TIMER_CTRL, 32'h3);
      pulse(1'b1, 1'b0);
      cnt = z;
      rd(OFS_STATUS, st(1'b1, cnt));
      set_lvl(1'b1, 1'b1);
      input_control_reg(FN_GATE_IO, EDGE_NONE, EDGE_NONE);
      rd(OFS_STATUS, st(1'b1, cnt));
      wr(OFS_TIMER_CTRL, 32'h1);
      input_control_reg(FN_IO_IO, EDGE_BOTH, EDGE_BOTH);
      pulse(1'b1, 1'b1);
      rd(OFS_STATUS, st(1'b1, cnt));
      repeat (2) @(posedge clk);
      test_done();
   end
endmodule
